/* logic/umhc_pkg.sv */
// package: register map and field layout of the modem handshake block
package umhc_pkg;
  localparam logic [7:0] MODEM_CONTROL_OFFS = 8'h10;
  localparam logic [7:0] MODEM_STATUS_OFFS = 8'h14;
  localparam logic [7:0] IRQ_ENABLE_OFFS = 8'h18;
  localparam logic [7:0] FLOW_CONFIG_OFFS = 8'h1C;
  localparam int RTS_CTRL_BIT = 1;
  localparam int RTS_POL_BIT = 9;
  localparam int RTS_LEVEL_BIT = 13;
  localparam int CTS_FLAG_BIT = 0;
  localparam int CTS_LEVEL_BIT = 4;
  localparam int CTS_POL_BIT = 8;
  localparam int MODEM_IRQ_ENABLE_BIT = 3;
  localparam int AUTO_FLOW_BIT = 0;
  localparam int RS485_MODE_BIT = 1;
  localparam int AUTO_DIR_BIT = 2;
  localparam logic [31:0] MODEM_CONTROL_RST = 32'h0000_0200;
  localparam logic [31:0] MODEM_STATUS_RST = 32'h0000_0110;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic auto_flow;
    logic rs485_mode;
    logic auto_dir;
  } umhc_flow_t;
endpackage

/* logic/umhc_ctrl.sv */
// module: modem handshake control and status with an axi4-lite slave
//
// Function
// - rts_pin_level at control bit 13 reads the level driven on rts.
// - control bit 9 sets rts polarity: 0 active high, 1 active low.
// - control bit 1 drives internal rts: 0 active, 1 inactive.
// - software rts bit ignored while auto-flow owns rts in uart mode.
// - software rts bit ignored while rs485 auto direction is on.
// - status bit 8 sets cts polarity: 0 high active, 1 low active.
// - status bit 4 reports the raw cts input level.
// - cts level updates only with clock enabled and cts function chosen.
// - cts change flag at bit 0 sets on any cts edge, stays set.
// - modem interrupt while change flag and modem_irq_enable bit 3 set.
// - writing one clears the change flag; zero writes ignored.
`timescale 1ns/1ps
module umhc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pclk_enable,
  input wire logic cts_func_sel,
  input wire logic flow_rts_active,
  input wire logic dir_rts_active,
  input wire logic cts_pin,
  output logic rts_pin,
  output logic cts_active,
  output logic modem_irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic rts_ctrl_q;
  logic rts_pol_q;
  logic cts_pol_q;
  logic cts_level_q;
  logic cts_flag_q;
  logic modem_irq_enable_q;
  umhc_pkg::umhc_flow_t flow_q;
  logic cts_meta_q;
  logic cts_sync_q;
  logic cts_prev_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic rts_int_active;
  logic rts_level_d;
  logic wr_fire;
  logic cts_edge;
  logic flag_clear;
  logic [31:0] rdata_d;
  logic rd_hit;
  logic wr_hit;

  // ---------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready)
                      && !s_axi_bvalid;
    end
  end

  always_comb begin
    case (awaddr_q)
      umhc_pkg::MODEM_CONTROL_OFFS, umhc_pkg::MODEM_STATUS_OFFS,
      umhc_pkg::IRQ_ENABLE_OFFS, umhc_pkg::FLOW_CONFIG_OFFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= umhc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? umhc_pkg::RESP_OKAY : umhc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // software fields
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_ctrl_q <= umhc_pkg::MODEM_CONTROL_RST[umhc_pkg::RTS_CTRL_BIT];
      rts_pol_q <= umhc_pkg::MODEM_CONTROL_RST[umhc_pkg::RTS_POL_BIT];
    end else if (wr_fire && awaddr_q == umhc_pkg::MODEM_CONTROL_OFFS) begin
      if (wstrb_q[0]) begin
        rts_ctrl_q <= wdata_q[umhc_pkg::RTS_CTRL_BIT];
      end
      if (wstrb_q[1]) begin
        rts_pol_q <= wdata_q[umhc_pkg::RTS_POL_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_pol_q <= umhc_pkg::MODEM_STATUS_RST[umhc_pkg::CTS_POL_BIT];
    end else if (wr_fire && awaddr_q == umhc_pkg::MODEM_STATUS_OFFS
                 && wstrb_q[1]) begin
      cts_pol_q <= wdata_q[umhc_pkg::CTS_POL_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_irq_enable_q <= 1'b0;
      flow_q <= '0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (awaddr_q == umhc_pkg::IRQ_ENABLE_OFFS) begin
        modem_irq_enable_q <= wdata_q[umhc_pkg::MODEM_IRQ_ENABLE_BIT];
      end
      if (awaddr_q == umhc_pkg::FLOW_CONFIG_OFFS) begin
        flow_q.auto_flow <= wdata_q[umhc_pkg::AUTO_FLOW_BIT];
        flow_q.rs485_mode <= wdata_q[umhc_pkg::RS485_MODE_BIT];
        flow_q.auto_dir <= wdata_q[umhc_pkg::AUTO_DIR_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // rts output
  // ---------------------------------------------------------------
  always_comb begin
    if (flow_q.rs485_mode && flow_q.auto_dir) begin
      rts_int_active = dir_rts_active;
    end else if (!flow_q.rs485_mode && flow_q.auto_flow) begin
      rts_int_active = flow_rts_active;
    end else begin
      rts_int_active = !rts_ctrl_q;
    end
    rts_level_d = rts_int_active ^ rts_pol_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_pin <= umhc_pkg::MODEM_CONTROL_RST[umhc_pkg::RTS_LEVEL_BIT];
    end else begin
      rts_pin <= rts_level_d;
    end
  end

  // ---------------------------------------------------------------
  // cts input
  // ---------------------------------------------------------------
  // first stage feeds only the second: no logic reads a metastable bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_meta_q <= 1'b1;
      cts_sync_q <= 1'b1;
      cts_prev_q <= umhc_pkg::MODEM_STATUS_RST[umhc_pkg::CTS_LEVEL_BIT];
    end else begin
      cts_meta_q <= cts_pin;
      cts_sync_q <= cts_meta_q;
      cts_prev_q <= cts_level_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_level_q <= umhc_pkg::MODEM_STATUS_RST[umhc_pkg::CTS_LEVEL_BIT];
    end else if (pclk_enable && cts_func_sel) begin
      cts_level_q <= cts_sync_q;
    end
  end

  assign cts_edge = cts_level_q != cts_prev_q;
  assign flag_clear = wr_fire && awaddr_q == umhc_pkg::MODEM_STATUS_OFFS
                      && wstrb_q[0] && wdata_q[umhc_pkg::CTS_FLAG_BIT];

  // a fresh edge wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_flag_q <= 1'b0;
    end else if (cts_edge) begin
      cts_flag_q <= 1'b1;
    end else if (flag_clear) begin
      cts_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_active <= 1'b0;
      modem_irq <= 1'b0;
    end else begin
      cts_active <= cts_level_q ^ cts_pol_q;
      modem_irq <= cts_flag_q && modem_irq_enable_q;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      umhc_pkg::MODEM_CONTROL_OFFS: begin
        rdata_d[umhc_pkg::RTS_CTRL_BIT] = rts_ctrl_q;
        rdata_d[umhc_pkg::RTS_POL_BIT] = rts_pol_q;
        rdata_d[umhc_pkg::RTS_LEVEL_BIT] = rts_pin;
      end
      umhc_pkg::MODEM_STATUS_OFFS: begin
        rdata_d[umhc_pkg::CTS_FLAG_BIT] = cts_flag_q;
        rdata_d[umhc_pkg::CTS_LEVEL_BIT] = cts_level_q;
        rdata_d[umhc_pkg::CTS_POL_BIT] = cts_pol_q;
      end
      umhc_pkg::IRQ_ENABLE_OFFS: begin
        rdata_d[umhc_pkg::MODEM_IRQ_ENABLE_BIT] = modem_irq_enable_q;
      end
      umhc_pkg::FLOW_CONFIG_OFFS: begin
        rdata_d[umhc_pkg::AUTO_FLOW_BIT] = flow_q.auto_flow;
        rdata_d[umhc_pkg::RS485_MODE_BIT] = flow_q.rs485_mode;
        rdata_d[umhc_pkg::AUTO_DIR_BIT] = flow_q.auto_dir;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= umhc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rd_hit ? umhc_pkg::RESP_OKAY : umhc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_edge_seen;
    cts_edge;
  endsequence
  sequence s_flag_up;
    ##1 cts_flag_q;
  endsequence
  property p_flag_sets;
    @(posedge aclk) disable iff (!aresetn) s_edge_seen |-> s_flag_up;
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("cts change flag not set after edge");
  property p_flag_clears;
    @(posedge aclk) disable iff (!aresetn)
      flag_clear && !cts_edge |=> !cts_flag_q;
  endproperty
  a_flag_clears: assert property (p_flag_clears)
    else $error("cts change flag not cleared by write of one");
  property p_flag_holds;
    @(posedge aclk) disable iff (!aresetn)
      cts_flag_q && !flag_clear |=> cts_flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("cts change flag dropped without a clear");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      modem_irq == $past(cts_flag_q && modem_irq_enable_q);
  endproperty
  a_irq: assert property (p_irq)
    else $error("modem interrupt does not follow flag and enable");
  property p_rts_sw;
    @(posedge aclk) disable iff (!aresetn)
      !flow_q.auto_flow && !flow_q.auto_dir |=>
      rts_pin == ($past(!rts_ctrl_q) ^ $past(rts_pol_q));
  endproperty
  a_rts_sw: assert property (p_rts_sw)
    else $error("rts pin level wrong for control and polarity");
  property p_rts_flow;
    @(posedge aclk) disable iff (!aresetn)
      !flow_q.rs485_mode && flow_q.auto_flow |=>
      rts_pin == ($past(flow_rts_active) ^ $past(rts_pol_q));
  endproperty
  a_rts_flow: assert property (p_rts_flow)
    else $error("rts not owned by auto flow logic");
  property p_rts_dir;
    @(posedge aclk) disable iff (!aresetn)
      flow_q.rs485_mode && flow_q.auto_dir |=>
      rts_pin == ($past(dir_rts_active) ^ $past(rts_pol_q));
  endproperty
  a_rts_dir: assert property (p_rts_dir)
    else $error("rts not owned by direction logic");
  property p_cts_frozen;
    @(posedge aclk) disable iff (!aresetn)
      !(pclk_enable && cts_func_sel) |=> $stable(cts_level_q);
  endproperty
  a_cts_frozen: assert property (p_cts_frozen)
    else $error("cts level moved while not enabled");
  property p_cts_sync;
    @(posedge aclk) disable iff (!aresetn)
      pclk_enable && cts_func_sel |=> cts_level_q == $past(cts_pin, 3);
  endproperty
  a_cts_sync: assert property (p_cts_sync)
    else $error("cts level not the pin three cycles back");
  property p_cts_pol;
    @(posedge aclk) disable iff (!aresetn)
      cts_active == $past(cts_level_q ^ cts_pol_q);
  endproperty
  a_cts_pol: assert property (p_cts_pol)
    else $error("cts active wrong for polarity");
endmodule

/* test/umhc_peer.sv */
// partner model: far-side serial peer driving the clear-to-send line
`timescale 1ns/1ps
module umhc_peer (
  input wire logic cts_want,
  input wire logic slow,
  output logic cts_pin
);
  // --------------------------------------------------------------
  // clear-to-send driver
  // --------------------------------------------------------------
  // delays are off the clock grid: the pin is truly asynchronous
  initial begin
    cts_pin = 1'b1;
    forever begin
      @(cts_want);
      if (slow) begin
        #137 cts_pin = cts_want;
      end else begin
        #7 cts_pin = cts_want;
      end
    end
  end
endmodule

/* test/umhc_ctrl_bench.sv */
// testbench: modem handshake block driven over axi4-lite
`timescale 1ns/1ps
module umhc_ctrl_bench;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam logic [7:0] CTL = umhc_pkg::MODEM_CONTROL_OFFS;
  localparam logic [7:0] STA = umhc_pkg::MODEM_STATUS_OFFS;
  localparam logic [7:0] IEN = umhc_pkg::IRQ_ENABLE_OFFS;
  localparam logic [7:0] FLW = umhc_pkg::FLOW_CONFIG_OFFS;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic pclk_en = 1'b1, func_sel = 1'b1, flow_act = 1'b0, dir_act = 1'b0;
  logic cts_want = 1'b1, slow = 1'b0;
  logic cts, rts, cts_act, irq;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'hF940_4CF1;

  always #12.5 aclk = ~aclk;

  // bready and rready held high: the answer is always accepted at once
  umhc_ctrl DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .pclk_enable(pclk_en), .cts_func_sel(func_sel),
    .flow_rts_active(flow_act), .dir_rts_active(dir_act), .cts_pin(cts),
    .rts_pin(rts), .cts_active(cts_act), .modem_irq(irq));
  umhc_peer PEER (.cts_want(cts_want), .slow(slow), .cts_pin(cts));

  // --------------------------------------------------------------
  // checking and bus tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic hang;
    err_count++;
    $display("[FAIL] bus answer expected 1 seen 0");
    complete_run;
  endtask

  // entered just after a rising edge; valid held until its ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 40) hang;
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 40) hang;
    d = rdata;
    r = rresp;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_word(nm, e, d);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // direction logic wins in rs485 mode with auto direction on; auto flow only outside it
  function automatic logic exp_rts(input logic [31:0] c,
      input logic [2:0] f, input logic fa, input logic da);
    logic act;
    act = (f[1] && f[2]) ? da : (f[0] && !f[1]) ? fa : !c[1];
    return act ^ c[9];
  endfunction

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] c, d;
    logic [1:0] r;
    logic [2:0] f;
    logic e, lvl, pol, ien;
    int i;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("control reset", CTL, umhc_pkg::MODEM_CONTROL_RST);
    rchk("status reset", STA, umhc_pkg::MODEM_STATUS_RST);
    // first four passes walk every control and polarity pairing
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      c = (i < 4) ? {22'h0, i[1], 7'h0, i[0], 1'b0} : seed;
      f = (i < 4) ? 3'h0 : seed[18:16];
      flow_act <= seed[20];
      dir_act <= seed[21];
      wreg(FLW, {29'h0, f});
      wreg(CTL, c);
      repeat (2) @(posedge aclk);
      e = exp_rts(c, f, seed[20], seed[21]);
      chk_bit("rts pin", e, rts);
      rchk("control", CTL, {18'h0, e, 3'h0, c[9], 7'h0, c[1], 1'b0});
    end
    wreg(FLW, 32'h0);
    lvl = 1'b1;
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      pol = seed[0];
      ien = (i != 3);
      slow <= i[0];
      wreg(IEN, {28'h0, ien, 3'h0});
      lvl = ~lvl;
      cts_want <= lvl;
      repeat (14) @(posedge aclk);
      wreg(STA, {23'h0, pol, 8'h00});
      rchk("status", STA, {23'h0, pol, 3'h0, lvl, 3'h0, 1'b1});
      chk_bit("cts active", lvl ^ pol, cts_act);
      chk_bit("irq set", ien, irq);
      wreg(STA, {23'h0, pol, 8'h01});
      rchk("status clear", STA, {23'h0, pol, 3'h0, lvl, 4'h0});
      chk_bit("irq clear", 1'b0, irq);
    end
    // gated: level must hold while either enable is low
    pclk_en <= 1'b0;
    lvl = ~lvl;
    cts_want <= lvl;
    repeat (14) @(posedge aclk);
    rd(STA, d, r);
    chk_bit("level clock off", ~lvl, d[4]);
    pclk_en <= 1'b1;
    func_sel <= 1'b0;
    repeat (14) @(posedge aclk);
    rd(STA, d, r);
    chk_bit("level func off", ~lvl, d[4]);
    func_sel <= 1'b1;
    repeat (14) @(posedge aclk);
    rd(STA, d, r);
    chk_bit("level enabled", lvl, d[4]);
    wr(8'h20, 32'hFFFF_FFFF, r);
    chk_word("unmapped bresp", {30'h0, umhc_pkg::RESP_SLVERR}, {30'h0, r});
    rd(8'h20, d, r);
    chk_word("unmapped rresp", {30'h0, umhc_pkg::RESP_SLVERR}, {30'h0, r});
    chk_word("unmapped rdata", 32'h0, d);
    // byte lanes: lane 0 holds the rts control, lane 1 the polarity
    wreg(CTL, 32'h0000_0202);
    wstrb <= 4'h1;
    wreg(CTL, 32'h0000_0000);
    rchk("lane 0 only", CTL, 32'h0000_0200);
    wstrb <= 4'h2;
    wreg(CTL, 32'h0000_0002);
    rchk("lane 1 only", CTL, 32'h0000_2000);
    wstrb <= 4'hF;
    complete_run;
  end
endmodule
